// *** src/vme_ip_carrier_pkg.sv ***
/*
  constants for the four-slot carrier address decoder and interrupt router:
  window sizes, region limits, address modifiers, register indices and the
  preset interrupt maps.
  assumes nothing; used with full package scope, never imported.
*/
package vme_ip_carrier_pkg;

  // a16 window: 1 kbyte, four 256-byte slot regions
  localparam int          A16_SLOT_BITS   = 8;
  localparam logic [7:0]  A16_ID_START    = 8'h80;  // i/o below this
  localparam logic [7:0]  A16_REG_START   = 8'hC0;  // own registers
  localparam logic [7:0]  A16_ID_BASE_HI  = 8'h80;  // id offset base

  // memory window: total window bits = base + size code (a24)
  localparam logic [4:0]  MEM_A24_WIN_BASE = 5'h10; // 128k for code 1
  localparam logic [4:0]  MEM_A32_WIN_BITS = 5'h19; // 32 mbyte
  localparam logic [3:0]  MEM_SIZE_OFF     = 4'h0;
  localparam logic [3:0]  MEM_SIZE_A24_MAX = 4'h7;
  localparam logic [3:0]  MEM_SIZE_A32     = 4'hF;

  // address modifiers
  localparam logic [5:0]  AM_A16_USER  = 6'h29;
  localparam logic [5:0]  AM_A16_SUPV  = 6'h2D;
  localparam logic [5:0]  AM_A24_0     = 6'h39;
  localparam logic [5:0]  AM_A24_1     = 6'h3A;
  localparam logic [5:0]  AM_A24_2     = 6'h3D;
  localparam logic [5:0]  AM_A24_3     = 6'h3E;
  localparam logic [5:0]  AM_A32_0     = 6'h09;
  localparam logic [5:0]  AM_A32_1     = 6'h0A;
  localparam logic [5:0]  AM_A32_2     = 6'h0D;
  localparam logic [5:0]  AM_A32_3     = 6'h0E;

  // register port indices (slot config registers at 0..3)
  localparam logic [3:0]  REG_IRQ_CFG_A  = 4'h0;
  localparam logic [3:0]  REG_IRQ_CFG_D  = 4'h3;
  localparam logic [3:0]  REG_IP_INT     = 4'h4;
  localparam logic [3:0]  REG_VME_IRQ    = 4'h5;
  localparam logic [3:0]  REG_SWITCHES   = 4'h6;
  localparam logic [7:0]  IRQ_CFG_MASK   = 8'h77;

  // preset maps, one byte per slot {d,c,b,a}: [6:4] int1, [2:0] int0
  localparam logic [31:0] PRESET_NONE = 32'h0000_0000;
  localparam logic [31:0] PRESET_1    = 32'h0765_4321;
  localparam logic [31:0] PRESET_2    = 32'h1254_1254;
  localparam logic [31:0] PRESET_3    = 32'h1346_1346;
  localparam logic [31:0] PRESET_4    = 32'h4433_2211;

  // decoded space of a hit
  typedef enum logic [1:0] {
    SPACE_IO  = 2'b00,
    SPACE_ID  = 2'b01,
    SPACE_REG = 2'b10,
    SPACE_MEM = 2'b11
  } space_e;

endpackage

// *** src/vme_ip_carrier_decoder.sv ***
/*
  address decoder and interrupt router of a four-slot module carrier on
  a vme backplane: a16 window, a24/a32 memory window, preset or
  software-programmed mapping of eight slot interrupts onto irq1..irq7.
  assumes inputs synchronous to clock_i, switches static, and that the
  vme cycle engine presents one address per request cycle.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
// Summary of operation
// R01: compare a15-12 and a11-10 with switches
// R02: 1k a16 window, four 256-byte regions
// R03: first 128 bytes go to i/o space
// R04: low switch: 64-byte id, registers from 0xc0
// R05: high switch: registers hidden, 128-byte id
// R06: slots a..d at 0x000, 0x100, 0x200, 0x300
// R07: two ints per slot, any level 1..7
// R08: software routing only in positions 0..7
// R09: upper positions mirror lower presets
// R10: preset 0 none, preset 4 per slot
// R11: preset 1 maps a0..d0 to 1..7
// R12: preset 2 mapping table
// R13: preset 3 mapping table
// R14: memory size 0 disables memory decode
// R15: size codes 1..7 a24, f a32
// R16: equal slot sizes, placed consecutively
// R17: a24 base compares a23-20, a19-16
// R18: a32 base compares a31-28, a27-24
// R19: compare only bits above total window
// R20: a32 only with its modifiers, d08/d16
// R21: a24 only with its modifiers
// R22: switches sampled; reserved sizes never respond
`timescale 1ns/1ps
module vme_ip_carrier_decoder (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // configuration switches
  input  wire logic [3:0]  a16_base_upper_sw_i,
  input  wire logic [3:0]  a16_base_lower_sw_i,
  input  wire logic [3:0]  irq_map_sw_i,
  input  wire logic [3:0]  mem_size_sw_i,
  input  wire logic [3:0]  mem_base_upper_sw_i,
  input  wire logic [3:0]  mem_base_lower_sw_i,
  // vme address phase
  input  wire logic        vme_req_i,
  input  wire logic [31:0] vme_addr_i,
  input  wire logic [5:0]  vme_am_i,
  input  wire logic        vme_wide_i,
  // decode result
  output logic             dec_valid_o,
  output logic             dec_hit_o,
  output logic [1:0]       dec_slot_o,
  output logic [1:0]       dec_space_o,
  output logic [22:0]      dec_offset_o,
  // interrupts
  input  wire logic [7:0]  ip_int_i,
  output logic [6:0]       vme_irq_o,
  output logic [2:0]       irq_level_o,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [7:0]       reg_rdata_o
);

  // whole state of the block
  typedef struct packed {
    logic [3:0]  a16_up;     // sampled switches
    logic [3:0]  a16_lo;
    logic [3:0]  irq_map;
    logic [3:0]  mem_size;
    logic [3:0]  mem_up;
    logic [3:0]  mem_lo;
    logic [31:0] irq_cfg;    // byte per slot
    logic        valid;      // decode result
    logic        hit;
    logic [1:0]  slot;
    logic [1:0]  space;
    logic [22:0] offset;
    logic [6:0]  irq;        // vme level lines
    logic [2:0]  level;      // highest active level
    logic [7:0]  rdata;
  } state_s;

  state_s q;       // registered state
  state_s next_q;  // next state

  // preset lookup; reserved presets act as no mapping
  function automatic logic [31:0] preset_map(input logic [2:0] p);
    logic [31:0] m;
    m = vme_ip_carrier_pkg::PRESET_NONE;  // R10
    case (p)
      3'h1: m = vme_ip_carrier_pkg::PRESET_1;  // R11
      3'h2: m = vme_ip_carrier_pkg::PRESET_2;  // R12
      3'h3: m = vme_ip_carrier_pkg::PRESET_3;  // R13
      3'h4: m = vme_ip_carrier_pkg::PRESET_4;  // R10
      default: m = vme_ip_carrier_pkg::PRESET_NONE;
    endcase
    return m;
  endfunction

  // combinational decode helpers
  logic        regs_on;    // own registers visible
  logic        am_a16;
  logic        am_a24;
  logic        am_a32;
  logic        a16_hit;
  logic        mem_en;     // legal size code and modifier
  logic [4:0]  win_bits;   // total memory window bits
  logic [31:0] addr_m;     // address in window's space
  logic [31:0] base_m;     // base in window's space
  logic [31:0] win_mask;
  logic [31:0] slot_mask;
  logic        mem_hit;
  logic [31:0] eff_cfg;    // routing in force
  logic [6:0]  lines;
  logic [2:0]  lv;         // level programmed for one slot line

  // config registers and the a16 register space are reachable only in switch positions 0..7
  assign regs_on = ~q.irq_map[3];  // R04 R05 R08

  // address modifier classes
  always_comb begin
    am_a16 = (vme_am_i == vme_ip_carrier_pkg::AM_A16_USER) ||
             (vme_am_i == vme_ip_carrier_pkg::AM_A16_SUPV);
    am_a24 = (vme_am_i == vme_ip_carrier_pkg::AM_A24_0) ||  // R21
             (vme_am_i == vme_ip_carrier_pkg::AM_A24_1) ||
             (vme_am_i == vme_ip_carrier_pkg::AM_A24_2) ||
             (vme_am_i == vme_ip_carrier_pkg::AM_A24_3);
    am_a32 = (vme_am_i == vme_ip_carrier_pkg::AM_A32_0) ||  // R20
             (vme_am_i == vme_ip_carrier_pkg::AM_A32_1) ||
             (vme_am_i == vme_ip_carrier_pkg::AM_A32_2) ||
             (vme_am_i == vme_ip_carrier_pkg::AM_A32_3);
  end

  // a16 window match; only two lower switch bits carry address
  assign a16_hit = am_a16 &&
                   (vme_addr_i[15:12] == q.a16_up) &&     // R01
                   (vme_addr_i[11:10] == q.a16_lo[1:0]);  // R01 R02

  // memory window geometry from the size code
  always_comb begin
    mem_en   = 1'b0;
    win_bits = vme_ip_carrier_pkg::MEM_A32_WIN_BITS;
    addr_m   = vme_addr_i;
    base_m   = {q.mem_up, q.mem_lo, 24'h00_0000};  // R18
    if (q.mem_size == vme_ip_carrier_pkg::MEM_SIZE_OFF) begin
      mem_en = 1'b0;  // R14
    end else if (q.mem_size <= vme_ip_carrier_pkg::MEM_SIZE_A24_MAX) begin
      // 32k per slot doubling per step
      mem_en   = am_a24 && !vme_wide_i;  // R15 R21
      win_bits = vme_ip_carrier_pkg::MEM_A24_WIN_BASE + {1'b0, q.mem_size};
      addr_m   = {8'h00, vme_addr_i[23:0]};
      base_m   = {8'h00, q.mem_up, q.mem_lo, 16'h0000};  // R17
    end else if (q.mem_size == vme_ip_carrier_pkg::MEM_SIZE_A32) begin
      mem_en = am_a32 && !vme_wide_i;  // R15 R20
    end else begin
      mem_en = 1'b0;  // R22
    end
  end

  // only bits above the window are compared; a misaligned base
  // therefore snaps down to the aligned window rather than splitting it
  assign win_mask  = 32'hFFFF_FFFF << win_bits;  // R19
  assign slot_mask = 32'hFFFF_FFFF << (win_bits - 5'h02);
  assign mem_hit   = mem_en && (((addr_m ^ base_m) & win_mask) == 32'h0);

  // routing in force: software copy only when registers are visible
  assign eff_cfg = regs_on ? q.irq_cfg : preset_map(q.irq_map[2:0]);  // R09

  // level lines: any enabled slot interrupt programmed to that level
  always_comb begin
    lines = 7'h00;
    lv    = 3'h0;
    for (int i = 0; i < 8; i++) begin
      lv = eff_cfg[i*4 +: 3];  // R07
      if (ip_int_i[i] && (lv != 3'h0)) begin
        lines[lv - 3'h1] = 1'b1;
      end
    end
  end

  // next-state logic
  always_comb begin
    next_q = q;
    // switches are static but sampled so decode sees stable copies
    next_q.a16_up   = a16_base_upper_sw_i;  // R22
    next_q.a16_lo   = a16_base_lower_sw_i;
    next_q.irq_map  = irq_map_sw_i;
    next_q.mem_size = mem_size_sw_i;
    next_q.mem_up   = mem_base_upper_sw_i;
    next_q.mem_lo   = mem_base_lower_sw_i;

    // decode result, one cycle after the request
    next_q.valid  = vme_req_i;
    next_q.hit    = 1'b0;
    next_q.slot   = 2'b00;
    next_q.space  = vme_ip_carrier_pkg::SPACE_IO;
    next_q.offset = 23'h0;
    if (vme_req_i && a16_hit) begin
      next_q.hit  = 1'b1;
      next_q.slot = vme_addr_i[9:8];  // R02 R06
      if (vme_addr_i[7:0] < vme_ip_carrier_pkg::A16_ID_START) begin
        next_q.space  = vme_ip_carrier_pkg::SPACE_IO;  // R03
        next_q.offset = {16'h0, vme_addr_i[6:0]};
      end else if (regs_on &&
                   vme_addr_i[7:0] >= vme_ip_carrier_pkg::A16_REG_START) begin
        next_q.space  = vme_ip_carrier_pkg::SPACE_REG;  // R04
        next_q.offset = {17'h0, vme_addr_i[5:0]};
      end else begin
        // 64 bytes with registers visible, 128 without
        next_q.space  = vme_ip_carrier_pkg::SPACE_ID;  // R04 R05
        next_q.offset = {15'h0, vme_addr_i[7:0] -
                                vme_ip_carrier_pkg::A16_ID_BASE_HI};
      end
    end else if (vme_req_i && mem_hit) begin
      next_q.hit    = 1'b1;
      next_q.space  = vme_ip_carrier_pkg::SPACE_MEM;
      next_q.slot   = 2'((addr_m & ~win_mask) >> (win_bits - 5'h02));  // R16
      next_q.offset = 23'(addr_m & ~slot_mask);  // R16
    end

    // interrupt outputs and highest active level
    next_q.irq   = lines;
    next_q.level = 3'h0;
    for (int l = 1; l <= 7; l++) begin
      if (lines[l-1]) begin
        next_q.level = 3'(l);  // R07
      end
    end

    // register port; writes ignored while registers are hidden
    if (reg_we_i && regs_on &&
        reg_addr_i <= vme_ip_carrier_pkg::REG_IRQ_CFG_D) begin
      next_q.irq_cfg[reg_addr_i[1:0]*8 +: 8] =
        reg_wdata_i & vme_ip_carrier_pkg::IRQ_CFG_MASK;  // R08
    end
    next_q.rdata = 8'h00;
    if (reg_re_i) begin
      if (reg_addr_i <= vme_ip_carrier_pkg::REG_IRQ_CFG_D) begin
        next_q.rdata = regs_on ? q.irq_cfg[reg_addr_i[1:0]*8 +: 8] : 8'h00;
      end else if (reg_addr_i == vme_ip_carrier_pkg::REG_IP_INT) begin
        next_q.rdata = ip_int_i;
      end else if (reg_addr_i == vme_ip_carrier_pkg::REG_VME_IRQ) begin
        next_q.rdata = {1'b0, q.irq};
      end else if (reg_addr_i == vme_ip_carrier_pkg::REG_SWITCHES) begin
        next_q.rdata = {q.mem_size, q.irq_map};
      end else begin
        next_q.rdata = 8'h00;  // unmapped reads as zero
      end
    end

    // reset loads the preset chosen by the switch itself
    if (rst_i) begin
      next_q         = '0;
      next_q.irq_map = irq_map_sw_i;
      next_q.irq_cfg = preset_map(irq_map_sw_i[2:0]);  // R09
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    q <= next_q;
  end

  // outputs straight from state
  assign dec_valid_o  = q.valid;
  assign dec_hit_o    = q.hit;
  assign dec_slot_o   = q.slot;
  assign dec_space_o  = q.space;
  assign dec_offset_o = q.offset;
  assign vme_irq_o    = q.irq;
  assign irq_level_o  = q.level;
  assign reg_rdata_o  = q.rdata;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a16_window_a: assert property (  // R01
    vme_req_i && am_a16 && vme_addr_i[15:12] == q.a16_up &&
    vme_addr_i[11:10] == q.a16_lo[1:0] |=> dec_hit_o &&
    dec_space_o != vme_ip_carrier_pkg::SPACE_MEM)
    else $error("a16 window access not claimed");
  slot_region_a: assert property (  // R06
    vme_req_i && a16_hit |=> dec_slot_o == $past(vme_addr_i[9:8]))
    else $error("a16 slot region wrong");
  io_space_a: assert property (  // R03
    vme_req_i && a16_hit && !vme_addr_i[7] |=>
    dec_space_o == vme_ip_carrier_pkg::SPACE_IO)
    else $error("i/o space not selected");
  reg_space_a: assert property (  // R04
    vme_req_i && a16_hit && vme_addr_i[7:6] == 2'b11 && regs_on |=>
    dec_space_o == vme_ip_carrier_pkg::SPACE_REG)
    else $error("register space not selected");
  id_space_a: assert property (  // R05
    vme_req_i && a16_hit && vme_addr_i[7] && !regs_on |=>
    dec_space_o == vme_ip_carrier_pkg::SPACE_ID)
    else $error("id space not selected");
  reg_lock_a: assert property (  // R08
    reg_we_i && !regs_on |=> $stable(q.irq_cfg))
    else $error("hidden register was written");
  mem_off_a: assert property (  // R14
    vme_req_i && q.mem_size == vme_ip_carrier_pkg::MEM_SIZE_OFF &&
    !a16_hit |=> !dec_hit_o)
    else $error("memory answered while disabled");
  mem_a32_slot_a: assert property (  // R16
    vme_req_i && mem_hit &&
    q.mem_size == vme_ip_carrier_pkg::MEM_SIZE_A32 |=>
    dec_slot_o == $past(vme_addr_i[24:23]) &&
    dec_offset_o == $past(vme_addr_i[22:0]))
    else $error("a32 slot placement wrong");
  mem_am_a: assert property (  // R20
    dec_hit_o && dec_space_o == vme_ip_carrier_pkg::SPACE_MEM |->
    $past(am_a24 || am_a32) && !$past(vme_wide_i))
    else $error("memory hit with wrong modifier");
  preset_one_a: assert property (  // R11
    !regs_on && q.irq_map[2:0] == 3'h1 && ip_int_i == 8'h80 |=>
    vme_irq_o == 7'h00)
    else $error("slot d int1 mapped in preset one");
  level_prio_a: assert property (  // R07
    vme_irq_o[6] |-> irq_level_o == 3'h7)
    else $error("irq7 not highest priority");
  // at the largest a24 size only a23 is left to compare against the base
  mem_a24_base_a: assert property (  // R17
    vme_req_i && am_a24 && !vme_wide_i &&
    q.mem_size == vme_ip_carrier_pkg::MEM_SIZE_A24_MAX &&
    vme_addr_i[23] == q.mem_up[3] |=> dec_hit_o &&
    dec_space_o == vme_ip_carrier_pkg::SPACE_MEM)
    else $error("a24 memory window not claimed");
  preset_none_a: assert property (  // R10
    !regs_on && q.irq_map[2:0] == 3'h0 |=> vme_irq_o == 7'h00)
    else $error("preset zero routed an interrupt");

  io_hit_c:   cover property (dec_hit_o &&
    dec_space_o == vme_ip_carrier_pkg::SPACE_IO);
  reg_hit_c:  cover property (dec_hit_o &&
    dec_space_o == vme_ip_carrier_pkg::SPACE_REG);
  mem_hit_c:  cover property (dec_hit_o &&
    dec_space_o == vme_ip_carrier_pkg::SPACE_MEM);
  irq_c:      cover property (vme_irq_o != 7'h00);
  id_hit_c:   cover property (dec_hit_o &&
    dec_space_o == vme_ip_carrier_pkg::SPACE_ID);

endmodule

// *** src/vme_ip_carrier_decoder_end.sv ***
`timescale 1ns/1ps

// *** verification/vme_master_model.sv ***
/*
  far-side model: a vme master issuing single address phases and the
  four module slots raising their interrupt lines.
  assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ps
module vme_master_model (
  // clock
  input  wire logic        clock_i,
  // address phase toward the decoder
  output logic             vme_req_o,
  output logic [31:0]      vme_addr_o,
  output logic [5:0]       vme_am_o,
  output logic             vme_wide_o,
  // slot interrupt lines, level
  output logic [7:0]       ip_int_o
);
  // idle bus at time zero
  initial begin
    vme_req_o  = 1'h0;
    vme_addr_o = 32'h0000_0000;
    vme_am_o   = 6'h00;
    vme_wide_o = 1'h0;
    ip_int_o   = 8'h00;
  end

  // one address phase; released lines show the inverse so a stale
  // address can never pass for a held one
  task automatic cycle(input logic [31:0] addr, input logic [5:0] am,
                       input logic wide);
    @(posedge clock_i);
    vme_req_o  <= 1'h1;
    vme_addr_o <= addr;
    vme_am_o   <= am;
    vme_wide_o <= wide;
    @(posedge clock_i);
    vme_req_o  <= 1'h0;
    vme_addr_o <= ~addr;
    vme_am_o   <= ~am;
    vme_wide_o <= ~wide;
  endtask

  // slots change their request levels just after an edge
  task automatic raise(input logic [7:0] lines);
    @(posedge clock_i);
    ip_int_o <= lines;
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  self-checking bench of the carrier decoder: register port, interrupt
  routing for every preset, a16 and memory decode with refusals.
  assumes the far-side model drives the vme and slot interrupt inputs.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); end end
module testbench;
  logic        clock_i;  // 125 mhz clock
  logic        rst_i;    // synchronous reset
  logic [3:0]  sw_a16u, sw_a16l, sw_map, sw_size, sw_memu, sw_meml;
  logic        vme_req, vme_wide, dec_valid, dec_hit, reg_we, reg_re;
  logic [31:0] vme_addr;
  logic [5:0]  vme_am;
  logic [1:0]  dec_slot, dec_space;
  logic [22:0] dec_offset;
  logic [7:0]  ip_int, reg_wdata, reg_rdata;
  logic [6:0]  vme_irq;
  logic [2:0]  irq_level;
  logic [3:0]  reg_addr;
  int          failures = 0;
  int          n_tests = 0;

  vme_master_model i_vme_master_model (.clock_i(clock_i),
    .vme_req_o(vme_req), .vme_addr_o(vme_addr), .vme_am_o(vme_am),
    .vme_wide_o(vme_wide), .ip_int_o(ip_int));

  vme_ip_carrier_decoder i_vme_ip_carrier_decoder (.clock_i(clock_i),
    .rst_i(rst_i), .a16_base_upper_sw_i(sw_a16u),
    .a16_base_lower_sw_i(sw_a16l), .irq_map_sw_i(sw_map),
    .mem_size_sw_i(sw_size), .mem_base_upper_sw_i(sw_memu),
    .mem_base_lower_sw_i(sw_meml), .vme_req_i(vme_req),
    .vme_addr_i(vme_addr), .vme_am_i(vme_am), .vme_wide_i(vme_wide),
    .dec_valid_o(dec_valid), .dec_hit_o(dec_hit), .dec_slot_o(dec_slot),
    .dec_space_o(dec_space), .dec_offset_o(dec_offset),
    .ip_int_i(ip_int), .vme_irq_o(vme_irq), .irq_level_o(irq_level),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata));

  // free-running clock, 8 ns period
  initial begin
    clock_i = 1'h0;
    forever #4 clock_i = ~clock_i;
  end

  // verdict and end of run, reached from the main flow or the watchdog
  task automatic test_done();
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // register write: one strobe cycle
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_we <= 1'h1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock_i);
    reg_we <= 1'h0;
  endtask

  // register read: data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_re <= 1'h1; reg_addr <= a;
    @(posedge clock_i);
    reg_re <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask

  // one address phase and its one-cycle decode answer
  task automatic dec_chk(input logic [31:0] a, input logic [5:0] am,
    input logic w, input logic hit, input logic [1:0] sl, sp,
    input logic [22:0] off);
    i_vme_master_model.cycle(a, am, w);
    #1 `CHK({dec_valid, dec_hit}, {1'h1, hit})
    if (hit) `CHK({dec_slot, dec_space, dec_offset}, {sl, sp, off})
  endtask

  // slot lines in, routed level and irq vector out one cycle later
  task automatic irq_chk(input logic [7:0] l, input logic [2:0] lvl,
                         input logic [6:0] v);
    i_vme_master_model.raise(l);
    @(posedge clock_i);
    #1 `CHK({irq_level, vme_irq}, {lvl, v})
  endtask

  // config registers start at preset 1, software may reroute
  task automatic t_regs();
    reg_rd(4'h0, 8'h21);
    reg_rd(4'h3, 8'h07);
    reg_rd(4'hF, 8'h00);
    reg_wr(4'h0, 8'hFF);
    reg_rd(4'h0, 8'h77);
    reg_wr(4'h0, 8'h07);
    irq_chk(8'h01, 3'h7, 7'h40);
    irq_chk(8'h02, 3'h0, 7'h00);
  endtask

  // every preset in the register-free positions, line by line
  task automatic t_presets();
    logic [31:0] tab [6];
    logic [3:0]  lv;
    tab = '{32'h0, 32'h0765_4321, 32'h1254_1254, 32'h1346_1346,
            32'h4433_2211, 32'h0};
    for (int p = 0; p < 6; p++) begin
      @(posedge clock_i);
      sw_map <= 4'h8 + p[3:0];
      for (int k = 0; k < 8; k++) begin
        lv = tab[p][4*k +: 4];
        irq_chk(8'h01 << k, lv[2:0], (lv == 4'h0) ? 7'h00 :
                7'h01 << (lv - 4'h1));
      end
    end
    @(posedge clock_i);
    sw_map <= 4'h9;
    irq_chk(8'hFF, 3'h7, 7'h7F);
    reg_wr(4'h1, 8'h55);
    reg_rd(4'h1, 8'h00);
    reg_rd(4'h4, 8'hFF);
    reg_rd(4'h5, 8'h7F);
    reg_rd(4'h6, 8'h09);
  endtask

  // a16 regions in both register modes, base and modifier refusals
  task automatic t_a16();
    logic [7:0] offs [6];
    logic [7:0] o, ex;
    logic [1:0] sp;
    offs = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
    for (int m = 0; m < 2; m++) begin
      @(posedge clock_i);
      sw_map <= m ? 4'h9 : 4'h1;
      for (int s = 0; s < 4; s++) begin
        for (int j = 0; j < 6; j++) begin
          o = offs[j];
          sp = (o < 8'h80) ? 2'h0 : (o < 8'hC0 || m == 1) ? 2'h1 : 2'h2;
          ex = (sp == 2'h0) ? o : (sp == 2'h1) ? o - 8'h80 : o - 8'hC0;
          dec_chk({16'h0, 6'h18, s[1:0], o},
                  m ? 6'h2D : 6'h29, 1'h0, 1'h1, s[1:0], sp, {15'h0, ex});
        end
      end
    end
    dec_chk(32'h6400, 6'h29, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    dec_chk(32'h6000, 6'h39, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    @(posedge clock_i);
    sw_a16l <= 4'h1;
    dec_chk(32'h6405, 6'h29, 1'h0, 1'h1, 2'h0, 2'h0, 23'h5);
    dec_chk(32'h6005, 6'h29, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
  endtask

  // memory sizes 1..7, a32, and every refusal
  task automatic t_mem();
    logic [31:0] sz;
    logic [5:0]  ams [4];
    logic [5:0]  a32s [4];
    ams = '{6'h39, 6'h3A, 6'h3D, 6'h3E};
    a32s = '{6'h09, 6'h0A, 6'h0D, 6'h0E};
    @(posedge clock_i);
    sw_memu <= 4'h8;
    sw_meml <= 4'h0;
    for (int n = 1; n < 8; n++) begin
      @(posedge clock_i);
      sw_size <= n[3:0];
      sz = 32'h8000 << (n - 1);
      dec_chk(32'h80_0000 + 3 * sz + 5, ams[n % 4],
              1'h0, 1'h1, 2'h3, 2'h3, 23'h5);
    end
    dec_chk(32'h70_0005, 6'h39, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    dec_chk(32'h80_0005, 6'h09, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    dec_chk(32'h80_0005, 6'h39, 1'h1, 1'h0, 2'h0, 2'h0, 23'h0);
    @(posedge clock_i);
    sw_size <= 4'hF;
    sw_memu <= 4'hD;
    for (int k = 0; k < 4; k++) begin
      dec_chk(32'hD100_0007, a32s[k],
              1'h0, 1'h1, 2'h2, 2'h3, 23'h7);
    end
    dec_chk(32'hD100_0007, 6'h3D, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    dec_chk(32'hD100_0007, 6'h09, 1'h1, 1'h0, 2'h0, 2'h0, 23'h0);
    dec_chk(32'hE100_0007, 6'h0D, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    @(posedge clock_i);
    sw_size <= 4'h0;
    dec_chk(32'hD100_0007, 6'h0D, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    @(posedge clock_i);
    sw_size <= 4'h8;
    dec_chk(32'hD100_0007, 6'h0D, 1'h0, 1'h0, 2'h0, 2'h0, 23'h0);
    // misaligned base snaps down to the aligned 32 mbyte window
    @(posedge clock_i);
    sw_size <= 4'hF;
    sw_meml <= 4'h1;
    dec_chk(32'hD000_0007, 6'h09, 1'h0, 1'h1, 2'h0, 2'h3, 23'h7);
  endtask

  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    #100000;
    failures++;
    test_done();
  end

  // main sequence: switches set before and during reset
  initial begin
    rst_i = 1'h1; sw_a16u = 4'h6; sw_a16l = 4'h0; sw_map = 4'h1;
    sw_size = 4'h0; sw_memu = 4'hD; sw_meml = 4'h0;
    reg_we = 1'h0; reg_re = 1'h0; reg_addr = 4'h0; reg_wdata = 8'h00;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'h0;
    t_regs();
    t_presets();
    t_a16();
    t_mem();
    test_done();
  end
endmodule
